/* File: logic/sbwoe_host.sv */
// host controller that programs output enables by an SMBus block write
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module sbwoe_host
   import sbwoe_pkg::*;
#(
   parameter int QDIV = QTR_DIV
) (
   input  wire logic        clk,            // 100 MHz system clock
   input  wire logic        rstn,           // async reset, active low
   input  wire logic [3:0]  avs_address,    // byte address
   input  wire logic        avs_read,       // read strobe
   input  wire logic        avs_write,      // write strobe
   input  wire logic [31:0] avs_writedata,  // write data
   output logic      [31:0] avs_readdata,   // read data
   output logic             avs_waitrequest,// stall
   input  wire logic        scl_i,          // serial_bus_clock_pin level
   output logic             scl_o,          // clock drive value (always 0)
   output logic             scl_oe,         // clock pull-low enable
   input  wire logic        sda_i,          // serial_bus_data_pin level
   output logic             sda_o,          // data drive value (always 0)
   output logic             sda_oe,         // data pull-low enable
   output logic             busy            // transfer in progress
);
   // ======================================================================
   // pin synchronisers
   logic [1:0] pins_s;
   sbwoe_sync #(.W(2)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({scl_i, sda_i}),
      .q    (pins_s)
   );
   wire scl_s = pins_s[1];
   wire sda_s = pins_s[0];

   // ======================================================================
   // registers
   logic [17:0]  oe_q;
   logic [1:0]   cnt_q;
   logic         done_q, nack_q;
   logic         wait_q;
   logic [31:0]  rdata_q;
   wire sel_ctrl = (avs_address == REG_CTRL);
   wire sel_stat = (avs_address == REG_STATUS);
   wire sel_lo   = (avs_address == REG_DATA_LO);
   wire sel_hi   = (avs_address == REG_DATA_HI);
   sbwoe_state_t st_q;
   wire idle     = (st_q == SBW_IDLE);
   // config writes are held off while busy so the frame is never torn; a request
   // is taken at the edge where the registered waitrequest is low
   wire wr_cfg   = avs_write && (sel_lo || sel_hi);
   wire wr_ok    = avs_write && (!wr_cfg || idle);
   wire req_ok   = avs_read || wr_ok;
   wire wr_take  = avs_write && !wait_q;
   wire start_go = wr_take && sel_ctrl && avs_writedata[CTRL_START_B] && idle;
   wire [31:0] rd_mux = sel_ctrl ? {31'h0000_0000, !idle} :
                        sel_stat ? {30'h0000_0000, nack_q, done_q} :
                        sel_lo   ? {16'h0000, oe_q[15:0]} :
                        sel_hi   ? {22'h00_0000, cnt_q, 6'h00, oe_q[17:16]} :
                                   32'h0000_0000;
   logic ev_done, ev_nack;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_q  <= OE_RESET;
         cnt_q <= CNT_RESET;
      end else if (wr_take && sel_lo) begin
         oe_q[15:0] <= avs_writedata[15:0];
      end else if (wr_take && sel_hi) begin
         oe_q[17:16] <= avs_writedata[1:0];
         cnt_q       <= avs_writedata[CNT_LSB+1:CNT_LSB];
      end
   end

   // set beats clear on the sticky flags
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         done_q <= ev_done | (done_q & ~(wr_take && sel_stat && avs_writedata[STAT_DONE_B]));
         nack_q <= ev_nack | (nack_q & ~(wr_take && sel_stat && avs_writedata[STAT_NACK_B]));
      end
   end

   // waitrequest rests high and drops for exactly one cycle per request, so the
   // pin comes straight from a flop; the cost is one extra cycle on every access
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= !(req_ok && wait_q);
         rdata_q <= rd_mux;
      end
   end
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;

   // ======================================================================
   // frame builder: address, command, count, data
   logic [1:0] dcount;
   assign dcount = (cnt_q == 2'd0) ? 2'd1 : cnt_q;
   logic [2:0] byte_idx_q;
   logic [7:0] tx_byte;
   wire  [2:0] last_idx = 3'(dcount) + 3'd2;
   always_comb begin
      unique case (byte_idx_q)
         3'd0:    tx_byte = {DEV_ADDR, DIR_WRITE};
         3'd1:    tx_byte = CMD_CODE;
         3'd2:    tx_byte = {6'h00, dcount};
         3'd3:    tx_byte = oe_q[7:0];
         3'd4:    tx_byte = oe_q[15:8];
         3'd5:    tx_byte = {oe_q[17], oe_q[16], 6'h00};
         default: tx_byte = 8'h00;
      endcase
   end

   // ======================================================================
   // quarter-bit tick: four phases per bit give 100 kbit/s
   localparam int QW = $clog2(QDIV + 1);
   logic [QW-1:0] div_q;
   wire tick = (div_q == QW'(QDIV - 1));
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_q <= '0;
      end else begin
         div_q <= (tick || idle) ? '0 : div_q + QW'(1);
      end
   end

   // ======================================================================
   // bit engine
   logic [1:0] ph_q;
   logic [2:0] bit_q;
   logic       scl_low_q, sda_low_q;
   wire  last_ph = tick && (ph_q == 2'd3);
   wire  tx_bit  = tx_byte[bit_q];
   // an acknowledge only counts while the clock is really released, so a device
   // that stretches the clock reads as a refusal instead of a false acknowledge
   wire  ack_ok  = !sda_s && scl_s;
   wire  ack_smp = tick && (ph_q == 2'd2) && (st_q == SBW_ACK);
   logic ack_seen_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q       <= SBW_IDLE;
         ph_q       <= 2'd0;
         bit_q      <= 3'd7;
         byte_idx_q <= 3'd0;
         scl_low_q  <= 1'b0;
         sda_low_q  <= 1'b0;
         ack_seen_q <= 1'b0;
      end else begin
         if (tick) ph_q <= ph_q + 2'd1;
         if (ack_smp) ack_seen_q <= ack_ok;
         unique case (st_q)
            SBW_IDLE: begin
               ph_q <= 2'd0;
               if (start_go) begin
                  st_q       <= SBW_START;
                  byte_idx_q <= 3'd0;
                  bit_q      <= 3'd7;
               end
            end
            SBW_START: begin
               // data falls while clock high, then clock falls
               if (tick && ph_q == 2'd1) sda_low_q <= 1'b1;
               if (tick && ph_q == 2'd3) scl_low_q <= 1'b1;
               if (last_ph) st_q <= SBW_BYTE;
            end
            SBW_BYTE: begin
               if (tick && ph_q == 2'd0) sda_low_q <= !tx_bit;
               if (tick && ph_q == 2'd1) scl_low_q <= 1'b0;
               if (tick && ph_q == 2'd3) scl_low_q <= 1'b1;
               if (last_ph) begin
                  bit_q <= bit_q - 3'd1;
                  if (bit_q == 3'd0) st_q <= SBW_ACK;
               end
            end
            SBW_ACK: begin
               if (tick && ph_q == 2'd0) sda_low_q <= 1'b0; // release for device
               if (tick && ph_q == 2'd1) scl_low_q <= 1'b0;
               if (tick && ph_q == 2'd3) scl_low_q <= 1'b1;
               if (last_ph) begin
                  bit_q <= 3'd7;
                  // a missing ack or the last byte ends the frame on a whole byte
                  if (!ack_seen_q || byte_idx_q == last_idx) begin
                     st_q <= SBW_STOP;
                  end else begin
                     byte_idx_q <= byte_idx_q + 3'd1;
                     st_q       <= SBW_BYTE;
                  end
               end
            end
            SBW_STOP: begin
               // data low, clock released, then data released while clock high
               if (tick && ph_q == 2'd0) sda_low_q <= 1'b1;
               if (tick && ph_q == 2'd1) scl_low_q <= 1'b0;
               if (tick && ph_q == 2'd3) sda_low_q <= 1'b0;
               if (last_ph) st_q <= SBW_IDLE;
            end
            default: st_q <= SBW_IDLE;
         endcase
      end
   end

   // the frame is only counted good once the last data byte is acknowledged
   assign ev_done = last_ph && (st_q == SBW_ACK) && ack_seen_q
                    && (byte_idx_q == last_idx);
   assign ev_nack = last_ph && (st_q == SBW_ACK) && !ack_seen_q;

   // open-drain outputs straight from flip-flops
   sbwoe_pin_t scl_pin, sda_pin;
   assign scl_pin = '{o: 1'b0, oe: scl_low_q};
   assign sda_pin = '{o: 1'b0, oe: sda_low_q};
   assign scl_o   = scl_pin.o;
   assign scl_oe  = scl_pin.oe;
   assign sda_o   = sda_pin.o;
   assign sda_oe  = sda_pin.oe;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) busy <= 1'b0;
      else       busy <= !idle || start_go;
   end

   // ======================================================================
   // check helper: cycles in a row that the host has held the clock low
   localparam int HW       = QW + 1;
   localparam int HOLD_MAX = 2 * QDIV;
   logic [HW-1:0] scl_hold_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_hold_q <= '0;
      end else begin
         scl_hold_q <= scl_low_q ? scl_hold_q + HW'(1) : '0;
      end
   end

   // ======================================================================
   // checks
   // frame content
   addr_byte_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_BYTE && byte_idx_q == 3'd0) |-> tx_byte == 8'hD2)
      else $error("address byte is not 1101001 with write");
   cmd_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_BYTE && byte_idx_q == 3'd1) |-> tx_byte == 8'h00)
      else $error("command code not zero");
   count_range_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_idx_q == 3'd2) |-> (tx_byte >= 8'd1 && tx_byte <= 8'd3))
      else $error("byte count out of range");
   no_overrun_a: assert property (@(posedge clk) disable iff (!rstn)
      byte_idx_q <= 3'd5)
      else $error("more data bytes than device registers");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
      (byte_idx_q == 3'd5) |-> tx_byte[5:0] == 6'h00)
      else $error("reserved bits not zero");
   // bit timing and framing on the link; data must only move under a low clock
   msb_first_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_ACK && $past(st_q) == SBW_BYTE) |-> $past(bit_q) == 3'd0)
      else $error("byte did not end on bit 0");
   data_stable_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_BYTE && !scl_low_q) |-> $stable(sda_low_q))
      else $error("data changed while clock released");
   ack_release_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_ACK && ph_q != 2'd0) |-> !sda_low_q)
      else $error("host drives data during acknowledge");
   ack_sample_a: assert property (@(posedge clk) disable iff (!rstn)
      ack_smp |-> !scl_low_q)
      else $error("acknowledge sampled with clock held low");
   rate_div_a: assert property (@(posedge clk) disable iff (!rstn)
      tick |=> !tick)
      else $error("bit tick too fast");
   scl_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      scl_hold_q <= HW'(HOLD_MAX))
      else $error("clock held low longer than half a bit");
   start_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      start_go |=> st_q == SBW_START)
      else $error("start request did not open a frame");
   start_frame_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_START && tick && ph_q == 2'd1) |=> sda_low_q && !scl_low_q)
      else $error("start condition not data falling under high clock");
   stop_frame_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == SBW_STOP && last_ph) |=> idle && !sda_low_q && !scl_low_q)
      else $error("stop condition did not release both lines");
   idle_release_a: assert property (@(posedge clk) disable iff (!rstn)
      idle |-> !scl_low_q && !sda_low_q)
      else $error("line held low while idle");
   nack_stop_a: assert property (@(posedge clk) disable iff (!rstn)
      ev_nack |=> st_q == SBW_STOP)
      else $error("refused byte did not end the frame");
   busy_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      !busy |-> idle)
      else $error("frame running with busy low");
   // register side
   done_valid_a: assert property (@(posedge clk) disable iff (!rstn)
      ev_done |-> ack_seen_q && byte_idx_q >= 3'd3)
      else $error("done without acknowledged count");
   flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
      ev_done |=> done_q)
      else $error("done flag lost to a clear");
   cfg_stall_a: assert property (@(posedge clk) disable iff (!rstn)
      (wr_take && (sel_lo || sel_hi)) |-> idle)
      else $error("config written during a frame");
   wait_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      !wait_q |=> wait_q)
      else $error("waitrequest low for more than one cycle");
   cov_done_c: cover property (@(posedge clk) disable iff (!rstn) ev_done);
   cov_nack_c: cover property (@(posedge clk) disable iff (!rstn) ev_nack);
   cov_full_c: cover property (@(posedge clk) disable iff (!rstn)
      ev_done && byte_idx_q == 3'd5);
   cov_stall_c: cover property (@(posedge clk) disable iff (!rstn)
      wr_cfg && !idle);
endmodule

/* File: logic/sbwoe_pkg.sv */
// package: constants and types for the block-write output-enable host controller
package sbwoe_pkg;
   // ======================================================================
   // link constants
   localparam logic [6:0]  DEV_ADDR      = 7'h69;   // 1101001
   localparam logic        DIR_WRITE     = 1'b0;
   localparam logic [7:0]  CMD_CODE      = 8'h00;
   localparam int          MAX_COUNT     = 32;
   localparam int          NUM_CFG_BYTES = 3;
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          BUS_RATE_HZ   = 100_000;   // standard mode
   // one quarter of a bit period, rounded up so the bus rate is never exceeded
   localparam int          QTR_DIV       = (CLK_HZ + 4 * BUS_RATE_HZ - 1) / (4 * BUS_RATE_HZ);
   // ======================================================================
   // register map (byte addresses on Avalon-MM)
   localparam logic [3:0]  REG_CTRL      = 4'h0;  // wr: bit0 start, rd: bit0 busy
   localparam logic [3:0]  REG_STATUS    = 4'h4;  // rd: bit0 done, bit1 nack; wr1 clears
   localparam logic [3:0]  REG_DATA_LO   = 4'h8;  // outputs 0..15
   localparam logic [3:0]  REG_DATA_HI   = 4'hC;  // outputs 16..17, count
   localparam int          CTRL_START_B  = 0;
   localparam int          STAT_DONE_B   = 0;
   localparam int          STAT_NACK_B   = 1;
   localparam int          CNT_LSB       = 8;
   localparam logic [17:0] OE_RESET      = 18'h3_FFFF;
   localparam logic [1:0]  CNT_RESET     = 2'h3;
   // ======================================================================
   typedef enum logic [2:0] {
      SBW_IDLE  = 3'b000,
      SBW_START = 3'b001,
      SBW_BYTE  = 3'b010,
      SBW_ACK   = 3'b011,
      SBW_STOP  = 3'b100
   } sbwoe_state_t;

   typedef struct packed {
      logic o;    // drive low when oe
      logic oe;
   } sbwoe_pin_t;
endpackage

/* File: logic/sbwoe_sync.sv */
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module sbwoe_sync #(
   parameter int W = 2
) (
   input  wire logic         clk,   // system clock
   input  wire logic         rstn,  // async reset, active low
   input  wire logic [W-1:0] d,     // asynchronous inputs
   output logic      [W-1:0] q      // synchronised outputs
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '1;
         q      <= '1;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

/* File: testbench/sbwoe_dev_model.sv */
// device model: serial receiver holding the three output enable bytes
`timescale 1ns/1ps
module sbwoe_dev_model (
   input  wire logic       scl,                 // bus clock level
   input  wire logic       sda,                 // bus data level
   input  wire logic       low_power_request_n, // power-down request, active low
   input  wire logic       nack_en,             // refuse one byte
   input  wire logic [3:0] nack_at,             // index of the refused byte
   output logic            pull,                // pulls data low
   output logic [7:0]      hdr [0:2],           // address, command, count
   output logic [7:0]      cfg [0:2],           // output enable bytes
   output logic [3:0]      nrx                  // bytes taken this frame
);
   logic [7:0] sh;
   logic       on;
   logic       ackph;
   logic       ok;
   int         bitc;
   // =====================================================================
   // framing
   initial begin
      pull = 1'b0;
      on = 1'b0;
      ackph = 1'b0;
      bitc = 0;
      nrx = 4'h0;
      sh = 8'h00;
      hdr = '{default: 8'h00};
      cfg = '{default: 8'hFF};   // every output runs until programmed
   end
   always @(negedge sda) begin
      if (scl && low_power_request_n) begin
         on = 1'b1;
         ackph = 1'b0;
         bitc = 0;
         nrx = 4'h0;
      end
   end
   // a byte cut short by stop or restart never reaches a register
   always @(posedge sda) begin
      if (scl) on = 1'b0;
   end
   // raw sampling, no filter on a standard-rate bus
   always @(posedge scl) begin
      if (on && !ackph) begin
         sh = {sh[6:0], sda};   // msb first
         bitc = bitc + 1;
      end
   end
   // =====================================================================
   // byte handling; count and command are not used to steer storage
   always @(negedge scl) begin
      if (ackph) begin
         pull = 1'b0;
         ackph = 1'b0;
      end else if (on && bitc == 8) begin
         bitc = 0;
         ackph = 1'b1;
         ok = !(nack_en && nack_at == nrx) && (nrx != 0 || sh == 8'hD2);
         if (nrx < 3) hdr[nrx] = sh;
         else if (nrx < 6) cfg[nrx - 3] = sh;   // in order, extras dropped
         nrx = nrx + 1;
         pull = ok;   // only the acknowledge is driven, no stretching
         on = ok;
      end
   end
   // power-down releases the bus and leaves the bytes alone
   always @(negedge low_power_request_n) begin
      pull = 1'b0;
      on = 1'b0;
   end
endmodule

/* File: testbench/sbwoe_host_test.sv */
// bench: drives the host controller over Avalon-MM against the device model
`timescale 1ns/1ps
module sbwoe_host_test;
   import sbwoe_pkg::*;
   localparam int QD = 4;
   logic        clk, rstn, avs_read, avs_write, busy, avs_waitrequest;
   logic [3:0]  avs_address, nack_at, nrx;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic        scl_o, sda_o, scl_oe, sda_oe, pull, low_power_request_n, nack_en;
   logic [7:0]  hdr [0:2];
   logic [7:0]  cfg [0:2];
   logic [7:0]  exp_cfg [0:2] = '{default: 8'hFF};
   logic [17:0] oe;
   logic [1:0]  c;
   wire         scl_w = ~scl_oe;
   wire         sda_w = ~(sda_oe | pull);
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   time         t0;

   sbwoe_host #(.QDIV(QD)) i_dut (
      .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
   sbwoe_dev_model i_dev (
      .scl(scl_w), .sda(sda_w), .low_power_request_n(low_power_request_n),
      .nack_en(nack_en), .nack_at(nack_at), .pull(pull), .hdr(hdr), .cfg(cfg), .nrx(nrx));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a hung handshake or frame ends the run as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end
   // =====================================================================
   // helpers
   task automatic test_done();
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] eb(input logic [17:0] v, input int i);
      return (i == 0) ? v[7:0] : (i == 1) ? v[15:8] : {v[17:16], 6'h00};
   endfunction
   // the request stands until the rising edge at which waitrequest is seen low
   task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic run(input logic [17:0] v, input logic [1:0] n2, input logic [1:0] st,
                      input logic mid);
      int n;
      n = (n2 == 2'd0) ? 1 : int'(n2);
      av_wr(REG_DATA_LO, {16'h0000, v[15:0]});
      av_wr(REG_DATA_HI, {22'h00_0000, n2, 6'h00, v[17:16]});
      av_wr(REG_CTRL, 32'h0000_0001);
      while (busy !== 1'b1) @(negedge clk);
      @(posedge scl_w);
      t0 = $time;
      @(posedge scl_w);
      check(32'($time - t0), 32'(40 * QD));
      check({31'h0, busy}, 32'h0000_0001);
      @(posedge clk);
      if (mid) av_wr(REG_DATA_LO, {16'h0000, ~v[15:0]});   // must stall until idle
      while (busy !== 1'b0) @(negedge clk);
      @(posedge clk);
      av_rd(REG_STATUS, rd);
      check(rd, {30'h0000_0000, st});
      av_wr(REG_STATUS, 32'h0000_0003);
      if (st == 2'b01) begin
         check({24'h00_0000, hdr[0]}, 32'h0000_00D2);
         check({24'h00_0000, hdr[1]}, 32'h0000_0000);
         check({24'h00_0000, hdr[2]}, 32'(n));
         check({28'h000_0000, nrx}, 32'(n + 3));
         for (int i = 0; i < n; i++) exp_cfg[i] = eb(v, i);
      end
      for (int i = 0; i < 3; i++) begin
         check({24'h0, cfg[i]}, {24'h0, exp_cfg[i]});
      end
   endtask
   // =====================================================================
   // main sequence
   initial begin
      rstn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0000_0000;
      low_power_request_n = 1'b1;
      nack_en = 1'b0;
      nack_at = 4'h0;
      rd = $urandom(32'hb708);
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      av_rd(REG_DATA_LO, rd);
      check(rd, 32'h0000_FFFF);
      av_rd(REG_DATA_HI, rd);
      check(rd, 32'h0000_0303);
      av_rd(4'h2, rd);
      check(rd, 32'h0000_0000);
      // count 0 and 3 first, then random lengths; third frame meets a stalled write
      for (int k = 0; k < 6; k++) begin
         oe = 18'($urandom);
         c = (k == 0) ? 2'd0 : (k == 1) ? 2'd3 : 2'($urandom);
         run(oe, c, 2'b01, k == 2);
         av_rd(REG_DATA_LO, rd);
         check(rd, {16'h0000, (k == 2) ? ~oe[15:0] : oe[15:0]});
      end
      nack_en <= 1'b1;
      nack_at <= 4'h2;
      run(18'($urandom), 2'd3, 2'b10, 1'b0);
      check({28'h000_0000, nrx}, 32'h0000_0003);
      nack_en <= 1'b0;
      low_power_request_n <= 1'b0;
      run(18'($urandom), 2'd3, 2'b10, 1'b0);
      low_power_request_n <= 1'b1;
      av_rd(REG_STATUS, rd);
      check(rd, 32'h0000_0000);
      check({30'h0000_0000, scl_w, sda_w}, 32'h0000_0003);
      check({30'h0, scl_o, sda_o}, 32'h0000_0000);
      test_done();
   end
endmodule
